// File: logic/tpd_map.svh
/*
  Named constants of the three-phase deadtime core: command codes, mode and
  fault bit positions, status selectors, reset values and timing figures.
  Assumes a 50 ns core clock; the TPD_STEP_CYC and TPD_RST_CYC counts below are derived from CLK_NS.
*/
`ifndef TPD_MAP_SVH
`define TPD_MAP_SVH

// Command codes carried on cmd_code by the serial front end.
`define TPD_CMD_DT_SET      4'h1
`define TPD_CMD_CALIB       4'h2
`define TPD_CMD_FULLON_ARM  4'h3
`define TPD_CMD_MODE_SET    4'h4
`define TPD_CMD_MASK_SET    4'h5
`define TPD_CMD_CLR_INT     4'h6
`define TPD_CMD_READ        4'h7

// Bit positions inside the mode byte.
`define TPD_MODE_FULLON     0
`define TPD_MODE_DESAT_KEEP 1
`define TPD_MODE_ZERO_DT    2
`define TPD_MODE_LOCK       3

// Bit positions of the fault status byte.
`define TPD_FLT_OVERCUR     0
`define TPD_FLT_DESAT       1
`define TPD_FLT_PHASE       2
`define TPD_FLT_UNDERV      3

// Status read selectors.
`define TPD_SEL_FAULT       8'h00
`define TPD_SEL_MODE        8'h01
`define TPD_SEL_DT          8'h02
`define TPD_SEL_CALIB       8'h03

// Reset values.
`define TPD_MASK_RST        4'hf
`define TPD_DT_RST          8'h00
`define TPD_MODE_RST        4'h0

// Timing figures, in their own units, and the counts derived from them.
`define TPD_CLK_NS          50
`define TPD_DT_STEP_NS      50
`define TPD_DT_MAX_NS       12000
`define TPD_DT_MAX_STEPS    ((`TPD_DT_MAX_NS) / (`TPD_DT_STEP_NS))
`define TPD_STEP_CYC        (((`TPD_DT_STEP_NS) + (`TPD_CLK_NS) - 1) / (`TPD_CLK_NS))
`define TPD_RST_NS          77
`define TPD_RST_CYC         ((`TPD_RST_NS) / (`TPD_CLK_NS))

`endif

// File: logic/tpd_pkg.sv
/*
  Types and shared arithmetic of the three-phase deadtime core.
  Assumes tpd_map.svh is on the include path.
*/
`include "tpd_map.svh"

package tpd_pkg;

  // Which gate of a phase the last leading edge selected; Gray along NONE-LS-HS.
  typedef enum logic [1:0] {
    TPD_SEL_NONE = 2'b00,
    TPD_SEL_LS   = 2'b01,
    TPD_SEL_HS   = 2'b11
  } tpd_sel_t;

  // Deadtime in clock cycles from the step count and the calibrated step length.
  function automatic logic [11:0] tpd_dt_cycles(input logic [7:0] steps,
                                               input logic [3:0] cyc_per_step);
    logic [11:0] prod;
    prod = 12'(steps) * 12'(cyc_per_step);
    return prod;
  endfunction : tpd_dt_cycles

endpackage : tpd_pkg

// File: logic/tpd_phase.sv
/*
  One phase of the shoot-through guard: edge-selected gate, deadtime timer.
  Assumes both command inputs are already synchronised and active high.
*/
`timescale 1ns/1ps

module tpd_phase
  import tpd_pkg::*;
#(
  parameter int DTW = 12
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           hs_act,
  input  wire logic           ls_act,
  input  wire logic [DTW-1:0] dt_cycles,
  input  wire logic           fullon,
  input  wire logic           kill,
  output logic                hs_gate,
  output logic                ls_gate
);

  // Parameter check at elaboration; a narrower timer cannot hold the longest deadtime.
  if (DTW < 12) begin : g_chk_dtw
    $error("DTW too narrow for the deadtime range");
  end

  logic           hs_prev_reg;
  logic           ls_prev_reg;
  tpd_sel_t       sel_reg;
  tpd_sel_t       sel_next;
  logic [DTW-1:0] timer_reg;
  logic           hs_gate_reg;
  logic           ls_gate_reg;
  logic           hs_gate_next;
  logic           ls_gate_next;
  logic           hs_rise;
  logic           ls_rise;

  // Leading edges choose the side; equal edges in one cycle select neither.
  assign hs_rise = hs_act & ~hs_prev_reg;
  assign ls_rise = ls_act & ~ls_prev_reg;

  always_comb begin
    sel_next = sel_reg;
    if (hs_rise && ls_rise) begin
      sel_next = TPD_SEL_NONE;
    end else if (hs_rise) begin
      sel_next = TPD_SEL_HS;
    end else if (ls_rise) begin
      sel_next = TPD_SEL_LS;
    end
  end

  // Gate decision. Demanding the other gate already off makes overlap
  // impossible even with a zero deadtime, at the cost of one cycle.
  always_comb begin
    if (fullon) begin
      hs_gate_next = hs_act & ~kill;
      ls_gate_next = ls_act & ~kill;
    end else begin
      hs_gate_next = hs_act & (sel_next == TPD_SEL_HS) & (timer_reg == '0)
                     & ~ls_gate_reg & ~kill;
      ls_gate_next = ls_act & (sel_next == TPD_SEL_LS) & (timer_reg == '0)
                     & ~hs_gate_reg & ~kill;
    end
  end

  // Edge history and selection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hs_prev_reg <= 1'b0;
      ls_prev_reg <= 1'b0;
      sel_reg     <= TPD_SEL_NONE;
    end else begin
      hs_prev_reg <= hs_act;
      ls_prev_reg <= ls_act;
      sel_reg     <= sel_next;
    end
  end

  // Deadtime timer starts on every gate turn-off; blanking is off in full-on.
  always_ff @(posedge clk) begin
    if (!rst_b || fullon) begin
      timer_reg <= '0;
    end else if ((hs_gate_reg && !hs_gate_next) || (ls_gate_reg && !ls_gate_next)) begin
      timer_reg <= dt_cycles;
    end else if (timer_reg != '0) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  // Gate registers; reset holds both off.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hs_gate_reg <= 1'b0;
      ls_gate_reg <= 1'b0;
    end else begin
      hs_gate_reg <= hs_gate_next;
      ls_gate_reg <= ls_gate_next;
    end
  end

  assign hs_gate = hs_gate_reg;
  assign ls_gate = ls_gate_reg;

  a_no_overlap: assert property (@(posedge clk) disable iff (!rst_b)
    !fullon |-> !(hs_gate_reg && ls_gate_reg))
    else $error("both gates of a phase on outside full-on mode");

  a_edge_kill: assert property (@(posedge clk) disable iff (!rst_b)
    (hs_rise && !fullon) |=> !ls_gate_reg)
    else $error("low gate not dropped on high-side leading edge");

  a_timer_load: assert property (@(posedge clk) disable iff (!rst_b)
    (ls_gate_reg && !ls_gate_next && !fullon) |=> (timer_reg == $past(dt_cycles)))
    else $error("deadtime timer not loaded on turn-off");

  a_timer_block: assert property (@(posedge clk) disable iff (!rst_b)
    (timer_reg != '0 && !fullon) |=> !$rose(hs_gate_reg) && !$rose(ls_gate_reg))
    else $error("gate turned on while deadtime was running");

  a_fast_on: assert property (@(posedge clk) disable iff (!rst_b)
    (hs_rise && !ls_rise && timer_reg == '0 && !ls_gate_reg && !kill && !fullon)
    |=> hs_gate_reg)
    else $error("late turn-on command was delayed");

  a_full_follow: assert property (@(posedge clk) disable iff (!rst_b)
    (fullon && !kill) |=> (ls_gate_reg == $past(ls_act)))
    else $error("full-on gate does not follow its input");

endmodule : tpd_phase

// File: logic/tpd_top.sv
/*
  Logic and control core of a three-phase gate pre-driver: pin synchronisers,
  command decode from the serial front end, modes, fault latching, status
  read-back and three deadtime-guarded phases.
  Assumes cmd_* come from serial logic on clk; phase and fault pins are async.
*/
`timescale 1ns/1ps
`include "tpd_map.svh"

module tpd_top
  import tpd_pkg::*;
#(
  parameter int PHASES = 3,
  parameter int DTW    = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [PHASES-1:0] high_side_cmd_in_b,
  input  wire logic [PHASES-1:0] low_side_cmd_in,
  input  wire logic [3:0]        fault_in,
  input  wire logic              cmd_valid,
  input  wire logic [3:0]        cmd_code,
  input  wire logic [7:0]        cmd_data,
  output logic [PHASES-1:0]      high_side_gate_out,
  output logic [PHASES-1:0]      low_side_gate_out,
  output logic                   int_out,
  output logic [7:0]             status_data,
  output logic                   status_valid
);

  localparam int RST_CYC = `TPD_RST_CYC;

  // Parameter checks at elaboration; a wrong value stops the build early.
  if (PHASES != 3) begin : g_chk_phases
    $error("core is built for three phases");
  end
  if (DTW < 12) begin : g_chk_dtw
    $error("DTW too narrow for the deadtime range");
  end
  if (RST_CYC < 1) begin : g_chk_rst
    $error("clock too slow to meet the reset time");
  end

  logic [PHASES-1:0] hs_meta_reg;
  logic [PHASES-1:0] hs_sync_reg;
  logic [PHASES-1:0] ls_meta_reg;
  logic [PHASES-1:0] ls_sync_reg;
  logic [3:0]        flt_meta_reg;
  logic [3:0]        flt_sync_reg;
  logic              arm_reg;
  logic              fullon_taken_reg;
  logic [3:0]        mode_reg;
  logic [7:0]        dt_steps_reg;
  logic [3:0]        cps_reg;
  logic [3:0]        mask_reg;
  logic [3:0]        fault_reg;
  logic [3:0]        fault_next;
  logic              int_reg;
  logic [7:0]        status_data_reg;
  logic              status_valid_reg;
  logic [DTW-1:0]    dt_cycles;
  logic              kill;
  logic              cmd_mode;
  logic              cmd_clr;
  logic              cmd_mask;

  // Pin synchronisers; reset values are the idle levels of the pulls.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hs_meta_reg  <= '1;
      hs_sync_reg  <= '1;
      ls_meta_reg  <= '0;
      ls_sync_reg  <= '0;
      flt_meta_reg <= '0;
      flt_sync_reg <= '0;
    end else begin
      hs_meta_reg  <= high_side_cmd_in_b;
      hs_sync_reg  <= hs_meta_reg;
      ls_meta_reg  <= low_side_cmd_in;
      ls_sync_reg  <= ls_meta_reg;
      flt_meta_reg <= fault_in;
      flt_sync_reg <= flt_meta_reg;
    end
  end

  assign cmd_mode = cmd_valid && (cmd_code == `TPD_CMD_MODE_SET);
  assign cmd_clr  = cmd_valid && (cmd_code == `TPD_CMD_CLR_INT);
  assign cmd_mask = cmd_valid && (cmd_code == `TPD_CMD_MASK_SET);

  // Arming lasts only until the next command, so a stray mode write cannot
  // turn on full-on by itself.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arm_reg <= 1'b0;
    end else if (cmd_valid) begin
      arm_reg <= (cmd_code == `TPD_CMD_FULLON_ARM);
    end
  end

  // Mode byte with lock and the once-only full-on choice.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg         <= `TPD_MODE_RST;
      fullon_taken_reg <= 1'b0;
    end else if (cmd_mode && !mode_reg[`TPD_MODE_LOCK]) begin
      mode_reg[`TPD_MODE_DESAT_KEEP] <= cmd_data[`TPD_MODE_DESAT_KEEP];
      mode_reg[`TPD_MODE_ZERO_DT]    <= cmd_data[`TPD_MODE_ZERO_DT];
      mode_reg[`TPD_MODE_LOCK]       <= cmd_data[`TPD_MODE_LOCK];
      if (arm_reg && !fullon_taken_reg) begin
        mode_reg[`TPD_MODE_FULLON] <= cmd_data[`TPD_MODE_FULLON];
        fullon_taken_reg           <= 1'b1;
      end
    end
  end

  // Deadtime steps, clamped to the top of the range, and calibrated step length.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dt_steps_reg <= `TPD_DT_RST;
      cps_reg      <= 4'(`TPD_STEP_CYC);
    end else if (cmd_valid && cmd_code == `TPD_CMD_DT_SET) begin
      dt_steps_reg <= (cmd_data > 8'(`TPD_DT_MAX_STEPS)) ? 8'(`TPD_DT_MAX_STEPS)
                                                          : cmd_data;
    end else if (cmd_valid && cmd_code == `TPD_CMD_CALIB && cmd_data[3:0] != 4'h0) begin
      cps_reg <= cmd_data[3:0];
    end
  end

  // One deadtime figure shared by all phases; zero-deadtime mode forces it off.
  assign dt_cycles = mode_reg[`TPD_MODE_ZERO_DT] ? '0
                   : DTW'(tpd_dt_cycles(dt_steps_reg, cps_reg));

  // Fault mask.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_reg <= `TPD_MASK_RST;
    end else if (cmd_valid && cmd_code == `TPD_CMD_MASK_SET) begin
      mask_reg <= cmd_data[3:0];
    end
  end

  // Sticky faults: a fault present in the clear cycle survives the clear.
  assign fault_next = (fault_reg & ~({4{cmd_clr}} & cmd_data[3:0])) | flt_sync_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fault_reg <= '0;
      int_reg   <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      int_reg   <= |(fault_reg & mask_reg);
    end
  end

  // A latched desaturation fault shuts every phase unless the mode keeps them.
  assign kill = fault_reg[`TPD_FLT_DESAT] & ~mode_reg[`TPD_MODE_DESAT_KEEP];

  // Status read-back, one cycle after the request.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_data_reg  <= 8'h00;
      status_valid_reg <= 1'b0;
    end else begin
      status_valid_reg <= cmd_valid && (cmd_code == `TPD_CMD_READ);
      if (cmd_valid && cmd_code == `TPD_CMD_READ) begin
        case (cmd_data)
          `TPD_SEL_FAULT: status_data_reg <= {4'h0, fault_reg};
          `TPD_SEL_MODE:  status_data_reg <= {3'h0, fullon_taken_reg, mode_reg};
          `TPD_SEL_DT:    status_data_reg <= dt_steps_reg;
          `TPD_SEL_CALIB: status_data_reg <= {4'h0, cps_reg};
          default:        status_data_reg <= 8'h00;
        endcase
      end
    end
  end

  // One guard per phase, each with its own timer.
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    tpd_phase #(
      .DTW (DTW)
    ) u_phase (
      .clk       (clk),
      .rst_b     (rst_b),
      .hs_act    (~hs_sync_reg[p]),
      .ls_act    (ls_sync_reg[p]),
      .dt_cycles (dt_cycles),
      .fullon    (mode_reg[`TPD_MODE_FULLON]),
      .kill      (kill),
      .hs_gate   (high_side_gate_out[p]),
      .ls_gate   (low_side_gate_out[p])
    );
  end

  assign int_out      = int_reg;
  assign status_data  = status_data_reg;
  assign status_valid = status_valid_reg;

  a_reset_off: assert property (@(posedge clk)
    !rst_b |=> (high_side_gate_out == '0) && (low_side_gate_out == '0))
    else $error("gates not off one edge after reset");

  // The interrupt lags the fault bits by one cycle, so a clear or mask write
  // one cycle back may still legitimately drop it.
  a_int_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (int_out && !cmd_clr && !$past(cmd_clr) && !cmd_mask && !$past(cmd_mask))
    |=> int_out)
    else $error("interrupt dropped without a clear");

  a_once_only: assert property (@(posedge clk) disable iff (!rst_b)
    fullon_taken_reg |=> $stable(mode_reg[`TPD_MODE_FULLON]))
    else $error("full-on changed after it was taken");

  a_lock_hold: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg[`TPD_MODE_LOCK] |=> $stable(mode_reg))
    else $error("locked mode changed");

  a_read_back: assert property (@(posedge clk) disable iff (!rst_b)
    (cmd_valid && cmd_code == `TPD_CMD_READ && cmd_data == `TPD_SEL_DT)
    |=> status_valid && (status_data == $past(dt_steps_reg)))
    else $error("status read returned the wrong value");

  a_dt_clamp: assert property (@(posedge clk) disable iff (!rst_b)
    (cmd_valid && cmd_code == `TPD_CMD_DT_SET) |=>
    dt_steps_reg <= 8'(`TPD_DT_MAX_STEPS))
    else $error("deadtime steps above range");

  a_arm_needed: assert property (@(posedge clk) disable iff (!rst_b)
    (cmd_mode && !arm_reg) |=> $stable(fullon_taken_reg))
    else $error("full-on choice taken without arming");

endmodule : tpd_top

// File: verif/tpd_mcu_model.sv
/*
  Controller model for the deadtime core: phase command pins, fault pins and
  the command strobe port, with tasks that the bench calls by hierarchy.
  Assumes one clock; every pin changes just after a falling edge of clk.
*/
`timescale 1ns/1ps
`include "tpd_map.svh"

module tpd_mcu_model
  import tpd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] status_data,
  input  wire logic       status_valid,
  output logic [2:0]      high_side_cmd_in_b,
  output logic [2:0]      low_side_cmd_in,
  output logic [3:0]      fault_in,
  output logic            cmd_valid,
  output logic [3:0]      cmd_code,
  output logic [7:0]      cmd_data
);
  // Pins start idle at their pulled levels so nothing is selected at power-up.
  initial begin
    high_side_cmd_in_b = 3'h7;
    low_side_cmd_in    = 3'h0;
    fault_in           = 4'h0;
    cmd_valid          = 1'b0;
    cmd_code           = 4'h0;
    cmd_data           = 8'h00;
  end

  // One-cycle strobe; code and data are inverted afterwards so stale values never look valid.
  task automatic send(input logic [3:0] code, input logic [7:0] data);
    @(negedge clk);
    cmd_code  = code;
    cmd_data  = data;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_data  = ~data;
  endtask : send

  // Read takes the answer in the cycle after the strobe, then looks once more.
  task automatic read(input logic [7:0] sel, output logic [7:0] d, output logic v1,
                      output logic v2);
    send(`TPD_CMD_READ, sel);
    v1 = status_valid;
    d  = status_data;
    @(negedge clk);
    v2 = status_valid;
  endtask : read

  // Step count first, then its calibrated length in clock cycles.
  task automatic set_deadtime(input logic [7:0] steps, input logic [7:0] cal);
    send(`TPD_CMD_DT_SET, steps);
    send(`TPD_CMD_CALIB, cal);
  endtask : set_deadtime

  // Full-on may only follow an arming command directly, guarding against accidents.
  task automatic arm_mode(input logic [7:0] mode);
    send(`TPD_CMD_FULLON_ARM, 8'h00);
    send(`TPD_CMD_MODE_SET, mode);
  endtask : arm_mode

  // High side is driven low to request, low side high.
  task automatic set_phase(input int ph, input logic hs_on, input logic ls_on);
    high_side_cmd_in_b[ph] = ~hs_on;
    low_side_cmd_in[ph]    = ls_on;
  endtask : set_phase

  // A fault level held for a few cycles, long enough to pass the synchronisers.
  task automatic pulse_fault(input logic [3:0] bits);
    @(negedge clk);
    fault_in = bits;
    repeat (3) @(negedge clk);
    fault_in = 4'h0;
  endtask : pulse_fault
endmodule : tpd_mcu_model

// File: verif/tpd_top_test.sv
/*
  Self-checking bench of the deadtime core: a table of deadtime settings, each run
  on one of the three phases, then reset, zero deadtime, full-on, locking and faults.
  Assumes tpd_map.svh is on the include path; the model drives every input but clk and rst_b.
*/
`timescale 1ns/1ps
`include "tpd_map.svh"

module tpd_top_test
  import tpd_pkg::*;
;
  typedef struct {
    int         ph;
    logic [7:0] steps;
    logic [7:0] cal;
    logic [7:0] rd_steps;
    logic [7:0] rd_cal;
    int         d;
  } tpd_row_t;

  logic       clk;
  logic       rst_b;
  logic       fullon_exp;
  logic [2:0] hs_cmd_b;
  logic [2:0] ls_cmd;
  logic [3:0] fault_in;
  logic       cmd_valid;
  logic [3:0] cmd_code;
  logic [7:0] cmd_data;
  logic [2:0] hs_g;
  logic [2:0] ls_g;
  logic       int_out;
  logic [7:0] status_data;
  logic       status_valid;
  int         miscompares;
  int         tests_run;
  // Calibration zero is refused and steps clamp at 240, so the last columns differ.
  tpd_row_t   rows [5] = '{
    '{0, 8'h00, 8'h01, 8'h00, 8'h01, 0},
    '{1, 8'h03, 8'h01, 8'h03, 8'h01, 3},
    '{2, 8'h05, 8'h02, 8'h05, 8'h02, 10},
    '{0, 8'h04, 8'h00, 8'h04, 8'h02, 8},
    '{1, 8'hfa, 8'h01, 8'hf0, 8'h01, 240}
  };

  tpd_top dut (.clk(clk), .rst_b(rst_b), .high_side_cmd_in_b(hs_cmd_b),
    .low_side_cmd_in(ls_cmd), .fault_in(fault_in), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .high_side_gate_out(hs_g),
    .low_side_gate_out(ls_g), .int_out(int_out), .status_data(status_data),
    .status_valid(status_valid));

  tpd_mcu_model mcu (.clk(clk), .status_data(status_data), .status_valid(status_valid),
    .high_side_cmd_in_b(hs_cmd_b), .low_side_cmd_in(ls_cmd), .fault_in(fault_in),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Checks run %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp_v);
    tests_run++;
    if (seen !== exp_v) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp_v);
    end
  endtask : check

  // Shoot-through watch on every settled cycle while full-on is not in force.
  always @(negedge clk) begin
    if (rst_b === 1'b1 && fullon_exp === 1'b0) begin
      check(16'(hs_g & ls_g), 16'h0000);
    end
  end

  // Counts falling edges until a gate reaches val; a bound keeps a hang short.
  task automatic wait_for(input logic hs_sel, input int ph, input logic val, inout int n);
    while ((hs_sel ? hs_g[ph] : ls_g[ph]) !== val) begin
      @(negedge clk);
      n++;
      if (n > 600) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask : wait_for

  task automatic rd(input logic [7:0] sel, input logic [7:0] exp_v);
    logic [7:0] d;
    logic       v1;
    logic       v2;
    mcu.read(sel, d, v1, v2);
    check({6'h00, v1, v2, d}, {8'h02, exp_v});
  endtask : rd

  // Pins cross two flops, so every latency below starts at three falling edges.
  task automatic run_row(input int ph, input int d);
    int n;
    @(negedge clk);
    mcu.set_phase(ph, 1'b0, 1'b1);
    n = 0;
    wait_for(1'b0, ph, 1'b1, n);
    check(16'(n), 16'h0003);
    @(negedge clk);
    mcu.set_phase(ph, 1'b1, 1'b1);
    n = 0;
    wait_for(1'b0, ph, 1'b0, n);
    check(16'(n), 16'h0003);
    wait_for(1'b1, ph, 1'b1, n);
    check(16'(n), 16'(d + 4));
    @(negedge clk);
    mcu.set_phase(ph, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    mcu.set_phase(ph, 1'b0, 1'b1);
    n = 0;
    wait_for(1'b0, ph, 1'b1, n);
    check(16'(n), 16'((d + 2 > 3) ? d + 2 : 3));
    @(negedge clk);
    mcu.set_phase(ph, 1'b0, 1'b0);
    repeat (d + 8) @(negedge clk);
  endtask : run_row

  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    for (int p = 0; p < 3; p++) mcu.set_phase(p, 1'b0, 1'b0);
    @(negedge clk);
    check({9'h000, hs_g, ls_g, int_out}, 16'h0000);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
  endtask : do_reset

  // Main sequence: table first, then the hand-written cases.
  initial begin
    miscompares = 0;
    tests_run   = 0;
    fullon_exp  = 1'b0;
    rst_b       = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    rd(`TPD_SEL_MODE, 8'h00);
    foreach (rows[i]) begin
      mcu.set_deadtime(rows[i].steps, rows[i].cal);
      rd(`TPD_SEL_DT, rows[i].rd_steps);
      rd(`TPD_SEL_CALIB, rows[i].rd_cal);
      run_row(rows[i].ph, rows[i].d);
    end
    mcu.set_phase(0, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    check(16'(ls_g[0]), 16'h0001);
    do_reset();
    rd(`TPD_SEL_DT, 8'h00);
    mcu.send(`TPD_CMD_DT_SET, 8'h0a);
    mcu.send(`TPD_CMD_MODE_SET, 8'h04);
    rd(`TPD_SEL_MODE, 8'h04);
    run_row(1, 0);
    do_reset();
    mcu.send(`TPD_CMD_MODE_SET, 8'h01);
    rd(`TPD_SEL_MODE, 8'h00);
    fullon_exp = 1'b1;
    mcu.arm_mode(8'h01);
    rd(`TPD_SEL_MODE, 8'h11);
    mcu.set_phase(2, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    check({14'h0000, hs_g[2], ls_g[2]}, 16'h0003);
    mcu.set_phase(2, 1'b0, 1'b0);
    mcu.arm_mode(8'h00);
    rd(`TPD_SEL_MODE, 8'h11);
    mcu.send(`TPD_CMD_MODE_SET, 8'h0c);
    rd(`TPD_SEL_MODE, 8'h1d);
    mcu.send(`TPD_CMD_MODE_SET, 8'h00);
    rd(`TPD_SEL_MODE, 8'h1d);
    // Faults: a masked-out type is latched but silent; a masked-in one holds int.
    mcu.send(`TPD_CMD_MASK_SET, 8'h01);
    mcu.pulse_fault(4'h4);
    repeat (8) @(negedge clk);
    check(16'(int_out), 16'h0000);
    rd(`TPD_SEL_FAULT, 8'h04);
    mcu.pulse_fault(4'h1);
    repeat (18) @(negedge clk);
    check(16'(int_out), 16'h0001);
    mcu.send(`TPD_CMD_CLR_INT, 8'h05);
    repeat (3) @(negedge clk);
    check(16'(int_out), 16'h0000);
    rd(`TPD_SEL_FAULT, 8'h00);
    mcu.set_phase(0, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    check(16'(ls_g[0]), 16'h0001);
    mcu.pulse_fault(4'h2);
    repeat (8) @(negedge clk);
    check({13'h0000, ls_g}, 16'h0000);
    // With the keep bit set, a desaturation fault is latched but leaves the gates on.
    do_reset();
    fullon_exp = 1'b0;
    mcu.send(`TPD_CMD_MODE_SET, 8'h02);
    mcu.set_phase(0, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    mcu.pulse_fault(4'h2);
    repeat (8) @(negedge clk);
    check(16'(ls_g[0]), 16'h0001);
    rd(`TPD_SEL_FAULT, 8'h02);
    report_and_stop();
  end
endmodule : tpd_top_test
